// ---- ccs_pkg.sv ----
// Purpose: Constants and types for the state and output clock control block.
// Assumes: A 200 MHz ref_clk and a 32-bit Avalon-MM register port.
// Notes: Register offsets are byte addresses of aligned words.
package ccs_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned F4_HZ = 4_000_000;
  localparam int unsigned F10_HZ = 10_000_000;
  localparam int unsigned F40_HZ = 40_000_000;
  // Half periods of the output clock in ref_clk cycles.
  localparam int unsigned HALF_4 = CLK_HZ / (2 * F4_HZ);
  localparam int unsigned HALF_10 = CLK_HZ / (2 * F10_HZ);
  localparam int unsigned HALF_40 = CLK_HZ / (2 * F40_HZ);
  // The 40 MHz period is an odd count, so its low phase is one cycle longer.
  localparam int unsigned LOW_40 = CLK_HZ / F40_HZ - HALF_40;
  // Power-on suppression time of the output clock, in ns.
  localparam int unsigned POR_NS = 1000;
  localparam int unsigned POR_CYC = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [7:0] OFS_MODULE_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_INIT_ACK = 8'h08;
  localparam logic [7:0] OFS_DEBUG_PORT = 8'h0C;
  localparam logic [7:0] OFS_BUF_SEL = 8'h10;
  localparam logic [7:0] OFS_BUF_CFG = 8'h14;

  // Module control word fields.
  localparam int unsigned BIT_CONFIG = 0;
  localparam int unsigned BIT_DIAG_HALT = 1;
  localparam int unsigned BIT_DEBUG_STATE = 2;
  localparam int unsigned BIT_LISTEN_ONLY = 3;
  localparam int unsigned BIT_SLEEP_REQ = 4;
  localparam int unsigned BIT_SLEEP_ACK = 5;
  localparam logic [31:0] MODULE_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] DEBUG_PORT_RST = 32'h0000_0000;
  // The acknowledge value is arbitrary.
  localparam logic [31:0] INIT_ACK_VALUE = 32'h0000_A5A5;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_HARD_RESET,
    ST_CONFIG,
    ST_DIAG_STOP,
    ST_NORMAL_ACTIVE,
    ST_NORMAL_PASSIVE,
    ST_LISTEN_ONLY,
    ST_DEBUG,
    ST_SLEEP
  } ccs_state_type;

endpackage

// ---- ccs_buf_mem.sv ----
// Purpose: Message buffer configuration store with registered read data.
// Assumes: One write or clear port and one read port.
// Notes: Words are cleared one per cycle during initialisation.
module ccs_buf_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned WIDTH = 32,
  parameter int unsigned AW = 4
) (
  // Clock.
  input wire logic ref_clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port.
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ---- ccs_ctrl.sv ----
// Purpose: Operating state control, output clock and debug pin routing.
// Assumes: Host reaches registers over Avalon-MM; pins pass a 3-stage sync.
// Notes: Protocol engine events arrive as same-clock inputs.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.

// Summary of operation
// - Output clock runs in every state except hard reset, where it is held low.
// - Output clock held low during power-on reset.
// - Select pins pick 4, 10, 40 MHz or low.
// - Hard reset loads register defaults.
// - Hard reset halts engine, bus and host port.
// - Host type straps captured leaving hard reset.
// - Initialisation starts when hard reset releases.
// - Initialisation clears all buffer configuration words.
// - Only acknowledge register served during initialisation.
// - Leaving hard reset enters configuration.
// - Buffers unused after hard reset, kept otherwise.
// - Config bit forces configuration immediately.
// - Clearing config bit enters normal active.
// - Diagnosis stop bit halts engine at once.
// - Diagnosis stop exits only to configuration.
// - Normal active transmits, receives and synchronises.
// - Mode bits steer exits from normal active.
// - Sync failure goes passive at cycle end.
// - Normal passive receives but never transmits.
// - Debug pins select functions independently.
// - Debug outputs off when guardian attached.
module ccs_ctrl
  import ccs_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 16,
  parameter int unsigned BUF_AW = 4,
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  // Clock and hard reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins.
  input wire logic freq_sel0,
  input wire logic freq_sel1,
  input wire logic host_type_sel0,
  input wire logic host_type_sel1,
  input wire logic guardian_attached,
  output logic ext_ref_clock_out,
  output logic debug_out1,
  output logic debug_out2,
  // Protocol engine side.
  input wire logic [15:0] debug_func_in,
  input wire logic sync_failed,
  input wire logic cycle_end,
  output logic [1:0] host_type,
  output logic [2:0] state_code,
  output logic engine_run,
  output logic tx_enable,
  output logic rx_enable,
  output logic sync_run,
  output logic host_if_run
);

  ccs_state_type state_reg, state_next;
  logic [31:0] mctrl_reg;
  logic [7:0] dbpc_reg;
  logic [BUF_AW-1:0] buf_sel_reg;
  logic init_busy_reg;
  logic [BUF_AW-1:0] init_ptr_reg;
  logic [1:0] released_reg;
  logic pass_pend_reg;
  logic [2:0] fs0_s, fs1_s;
  logic [2:0] ht0_s, ht1_s, ga_s;
  logic fs0_q, fs1_q, ga_q;
  logic [15:0] por_cnt_reg;
  logic [4:0] half_cnt_reg;
  logic [1:0] sel_reg;
  logic ack_reg;

  // Three-stage input synchronisers; select and guardian pins accepted when stages two and three agree.
  // They run through hard reset so the straps are settled when it ends.
  always_ff @(posedge ref_clk) begin
    fs0_s <= {fs0_s[1:0], freq_sel0};
    fs1_s <= {fs1_s[1:0], freq_sel1};
    ht0_s <= {ht0_s[1:0], host_type_sel0};
    ht1_s <= {ht1_s[1:0], host_type_sel1};
    ga_s <= {ga_s[1:0], guardian_attached};
    if (fs0_s[1] == fs0_s[2]) fs0_q <= fs0_s[2];
    if (fs1_s[1] == fs1_s[2]) fs1_q <= fs1_s[2];
    if (ga_s[1] == ga_s[2]) ga_q <= ga_s[2];
  end

  // Output clock generator.
  wire por_done = (por_cnt_reg == POR_CYCLES[15:0]);
  wire [1:0] sel_pin = {fs1_q, fs0_q};
  wire [4:0] half_lim = (sel_reg == 2'b00) ? HALF_4[4:0] - 5'h01 :
                        (sel_reg == 2'b01) ? HALF_10[4:0] - 5'h01 :
                        ext_ref_clock_out ? HALF_40[4:0] - 5'h01 :
                        LOW_40[4:0] - 5'h01;
  wire half_end = (half_cnt_reg == half_lim);
  wire at_boundary = half_end && ext_ref_clock_out;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_cnt_reg <= 16'h0000;
      half_cnt_reg <= 5'h00;
      sel_reg <= 2'b11;
      ext_ref_clock_out <= 1'b0;
    end else if (!por_done) begin
      por_cnt_reg <= por_cnt_reg + 16'h0001;
      sel_reg <= sel_pin;
    end else if (sel_reg == 2'b11) begin
      ext_ref_clock_out <= 1'b0;
      sel_reg <= sel_pin;
      half_cnt_reg <= 5'h00;
    end else if (half_end) begin
      half_cnt_reg <= 5'h00;
      ext_ref_clock_out <= ~ext_ref_clock_out;
      if (at_boundary) sel_reg <= sel_pin;
    end else begin
      half_cnt_reg <= half_cnt_reg + 5'h01;
    end
  end

  // Bus decode.
  wire is_ctrl = (avs_address == OFS_MODULE_CTRL);
  wire is_state = (avs_address == OFS_STATE);
  wire is_ack = (avs_address == OFS_INIT_ACK);
  wire is_dbpc = (avs_address == OFS_DEBUG_PORT);
  wire is_bsel = (avs_address == OFS_BUF_SEL);
  wire is_bcfg = (avs_address == OFS_BUF_CFG);
  wire host_ok = (state_reg != ST_HARD_RESET);
  wire allowed = host_ok && (!init_busy_reg || is_ack);
  wire req = (avs_read || avs_write) && !ack_reg;
  wire wr_ok = avs_write && ack_reg && allowed && (&avs_byteenable);
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] ctrl_wdata = (avs_writedata & be_mask) | (mctrl_reg & ~be_mask);

  // Every access takes one wait cycle; answer comes on the second edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_reg <= req;
      avs_waitrequest <= !req;
    end
  end

  // Buffer store, cleared at initialisation.
  logic [31:0] buf_rd;
  wire mem_we = init_busy_reg || (wr_ok && is_bcfg);
  wire [BUF_AW-1:0] mem_wa = init_busy_reg ? init_ptr_reg : buf_sel_reg;
  wire [31:0] mem_wd = init_busy_reg ? 32'h0000_0000 : avs_writedata;

  ccs_buf_mem #(
    .DEPTH(BUF_DEPTH),
    .WIDTH(32),
    .AW(BUF_AW)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(buf_sel_reg),
    .rd_data(buf_rd)
  );

  // Release detect, strap capture and initialisation walk.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      released_reg <= 2'b00;
      init_busy_reg <= 1'b0;
      init_ptr_reg <= '0;
      host_type <= 2'b00;
    end else begin
      released_reg <= {released_reg[0], 1'b1};
      if (released_reg == 2'b01) begin
        host_type <= {ht1_s[2], ht0_s[2]};
        init_busy_reg <= 1'b1;
        init_ptr_reg <= '0;
      end else if (init_busy_reg) begin
        init_ptr_reg <= init_ptr_reg + 1'b1;
        if (init_ptr_reg == BUF_AW'(BUF_DEPTH - 1)) init_busy_reg <= 1'b0;
      end
    end
  end

  // Host-written registers; hard reset defaults apply under rst.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mctrl_reg <= MODULE_CTRL_RST;
      dbpc_reg <= DEBUG_PORT_RST[7:0];
      buf_sel_reg <= '0;
    end else if (wr_ok) begin
      if (is_ctrl) mctrl_reg <= ctrl_wdata;
      if (is_dbpc) dbpc_reg <= avs_writedata[7:0];
      if (is_bsel) buf_sel_reg <= avs_writedata[BUF_AW-1:0];
    end
  end

  // Read data.
  wire [31:0] rd_mux = !allowed ? UNMAPPED_DATA :
                       is_ctrl ? mctrl_reg :
                       is_state ? {29'h0, state_code} :
                       is_ack ? (init_busy_reg ? 32'h0 : INIT_ACK_VALUE) :
                       is_dbpc ? {24'h0, dbpc_reg} :
                       is_bsel ? {{(32 - BUF_AW){1'b0}}, buf_sel_reg} :
                       is_bcfg ? buf_rd : UNMAPPED_DATA;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_mux;
    end
  end

  // State machine.
  wire b_cfg = mctrl_reg[BIT_CONFIG];
  wire b_diag = mctrl_reg[BIT_DIAG_HALT];
  wire b_dbg = mctrl_reg[BIT_DEBUG_STATE];
  wire b_lo = mctrl_reg[BIT_LISTEN_ONLY];
  wire b_slp = mctrl_reg[BIT_SLEEP_REQ] && mctrl_reg[BIT_SLEEP_ACK];
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HARD_RESET: state_next = ST_CONFIG;
      ST_CONFIG: if (!b_cfg && !init_busy_reg) state_next = ST_NORMAL_ACTIVE;
      ST_DIAG_STOP: if (b_cfg) state_next = ST_CONFIG;
      ST_NORMAL_ACTIVE: begin
        if (b_cfg) state_next = ST_CONFIG;
        else if (b_diag) state_next = ST_DIAG_STOP;
        else if (b_dbg) state_next = ST_DEBUG;
        else if (b_lo) state_next = ST_LISTEN_ONLY;
        else if (b_slp) state_next = ST_SLEEP;
        else if (pass_pend_reg && cycle_end) state_next = ST_NORMAL_PASSIVE;
      end
      ST_NORMAL_PASSIVE: begin
        if (b_cfg) state_next = ST_CONFIG;
        else if (b_diag) state_next = ST_DIAG_STOP;
        else if (b_dbg) state_next = ST_DEBUG;
        else if (b_slp) state_next = ST_SLEEP;
      end
      ST_LISTEN_ONLY, ST_DEBUG: if (b_cfg) state_next = ST_CONFIG;
      ST_SLEEP: if (!b_slp || b_cfg) state_next = ST_CONFIG;
    endcase
  end

  // Configuration is kept on re-entry; only hard reset empties buffers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_HARD_RESET;
      pass_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != ST_NORMAL_ACTIVE) pass_pend_reg <= 1'b0;
      else if (sync_failed) pass_pend_reg <= 1'b1;
    end
  end

  // State code reported together with the state register.
  assign state_code = 3'(state_reg);

  wire run_n = (state_next == ST_NORMAL_ACTIVE) ||
               (state_next == ST_NORMAL_PASSIVE);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      engine_run <= 1'b0;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      sync_run <= 1'b0;
      host_if_run <= 1'b0;
    end else begin
      engine_run <= run_n;
      tx_enable <= (state_next == ST_NORMAL_ACTIVE);
      rx_enable <= run_n;
      sync_run <= run_n;
      host_if_run <= (state_next != ST_HARD_RESET);
    end
  end

  // Debug pin routing, one selector nibble per pin.
  wire [1:0] dbg_pick;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dbg
      assign dbg_pick[gi] = debug_func_in[dbpc_reg[gi*4 +: 4]];
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_out1 <= 1'b0;
      debug_out2 <= 1'b0;
    end else begin
      debug_out1 <= dbg_pick[0] && !ga_q;
      debug_out2 <= dbg_pick[1] && !ga_q;
    end
  end

  // Assertions.
  property p_diag_exit;
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_DIAG_STOP |=> state_reg inside {ST_DIAG_STOP, ST_CONFIG};
  endproperty
  a_diag_exit: assert property (p_diag_exit) else $error("bad diag exit");
  property p_reset_to_cfg;
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_HARD_RESET |=> state_reg == ST_CONFIG;
  endproperty
  a_reset_to_cfg: assert property (p_reset_to_cfg) else $error("no cfg");
  property p_cfg_now;
    @(posedge ref_clk) disable iff (rst)
    (b_cfg && state_reg inside {ST_NORMAL_ACTIVE, ST_NORMAL_PASSIVE})
      |=> state_reg == ST_CONFIG;
  endproperty
  a_cfg_now: assert property (p_cfg_now) else $error("cfg late");
  property p_passive_tx;
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_NORMAL_PASSIVE |-> !tx_enable;
  endproperty
  a_passive_tx: assert property (p_passive_tx) else $error("tx passive");
  property p_passive_entry;
    @(posedge ref_clk) disable iff (rst)
    $rose(state_reg == ST_NORMAL_PASSIVE) |-> $past(cycle_end);
  endproperty
  a_passive_entry: assert property (p_passive_entry)
    else $error("passive early");
  property p_guard_off;
    @(posedge ref_clk) disable iff (rst)
    ga_q |=> !debug_out1 && !debug_out2;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("dbg on");
  property p_clk_low;
    @(posedge ref_clk) disable iff (rst)
    (por_done && sel_reg == 2'b11) |=> !ext_ref_clock_out;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clk not low");
  property p_init_gate;
    @(posedge ref_clk) disable iff (rst)
    (init_busy_reg && avs_read && !ack_reg && !is_ack)
      |=> avs_readdata == UNMAPPED_DATA;
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("init read");
  property p_diag_halt;
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_DIAG_STOP |-> ##1 !engine_run [*2];
  endproperty
  a_diag_halt: assert property (p_diag_halt) else $error("engine on");

  c_normal: cover property (@(posedge ref_clk) state_reg == ST_NORMAL_ACTIVE);
  c_passive: cover property (@(posedge ref_clk)
    state_reg == ST_NORMAL_PASSIVE);
  c_diag: cover property (@(posedge ref_clk) state_reg == ST_DIAG_STOP);
  c_clk: cover property (@(posedge ref_clk) $rose(ext_ref_clock_out));

endmodule

// ---- ccs_host_model.sv ----
// Purpose: Host controller model on the Avalon-MM register port.
// Assumes: One full-word request at a time.
// Notes: Idle address and data lines toggle so stale values are not seen.
module ccs_host_model
  import ccs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM master.
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    while (rst !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // Only the acknowledge word is polled until it shows completion.
  task automatic wait_init();
    logic [31:0] q;
    q = 32'h0000_0000;
    while (q !== INIT_ACK_VALUE) rd(OFS_INIT_ACK, q);
  endtask
endmodule

// ---- cc_state_and_ext_ref_clock_out_control_bench.sv ----
// Purpose: Self-checking bench for state and output clock control.
// Assumes: Short power-on count so the run stays brief.
// Notes: Each test is a task that checks its own results.
module cc_state_and_ext_ref_clock_out_control_bench
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POR_T = 10;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic freq_sel0 = 1'b0;
  logic freq_sel1 = 1'b0;
  // Board strap for the host bus type.
  logic host_type_sel0 = 1'b0;
  logic host_type_sel1 = 1'b1;
  logic guardian_attached = 1'b0;
  logic [15:0] debug_func_in = 16'h0000;
  logic sync_failed = 1'b0;
  logic cycle_end = 1'b0;
  logic ext_ref_clock_out;
  logic debug_out1;
  logic debug_out2;
  logic [1:0] host_type;
  logic [2:0] state_code;
  logic engine_run;
  logic tx_enable;
  logic rx_enable;
  logic sync_run;
  logic host_if_run;
  logic [4:0] flags;
  int err_total = 0;
  int checks = 0;

  assign flags = {engine_run, tx_enable, rx_enable, sync_run, host_if_run};

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  ccs_ctrl #(.POR_CYCLES(POR_T)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .freq_sel0(freq_sel0), .freq_sel1(freq_sel1),
    .host_type_sel0(host_type_sel0), .host_type_sel1(host_type_sel1),
    .guardian_attached(guardian_attached),
    .ext_ref_clock_out(ext_ref_clock_out), .debug_out1(debug_out1),
    .debug_out2(debug_out2), .debug_func_in(debug_func_in),
    .sync_failed(sync_failed), .cycle_end(cycle_end),
    .host_type(host_type), .state_code(state_code),
    .engine_run(engine_run), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .sync_run(sync_run), .host_if_run(host_if_run)
  );

  ccs_host_model u_host (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  task automatic chk_val(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    logic [31:0] q;
    u_host.rd(a, q);
    chk_val(what, exp, q);
  endtask

  // Writes the mode word, then checks the state pin and register.
  task automatic st_go(input logic [31:0] d, input ccs_state_type s);
    u_host.wr(OFS_MODULE_CTRL, d);
    repeat (2) @(posedge ref_clk);
    chk_val("state_pin", 32'(s), 32'(state_code));
    rd_chk("state_reg", OFS_STATE, 32'(s));
  endtask

  task automatic t_reset();
    logic [31:0] q;
    repeat (5) @(posedge ref_clk);
    chk_val("reset_state", 32'(ST_HARD_RESET), 32'(state_code));
    chk_val("reset_flags", 32'h0, 32'(flags));
    chk_val("reset_wait", 32'h1, 32'(avs_waitrequest));
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_val("after_reset", 32'(ST_CONFIG), 32'(state_code));
    chk_val("por_low", 32'h0, 32'(ext_ref_clock_out));
    u_host.rd(OFS_MODULE_CTRL, q);
    chk_val("ctrl_in_init", UNMAPPED_DATA, q);
    u_host.wait_init();
    chk_val("host_type", 32'h2, 32'(host_type));
    chk_val("cfg_flags", 32'h1, 32'(flags));
    rd_chk("ctrl_rst", OFS_MODULE_CTRL, MODULE_CTRL_RST);
    rd_chk("dbg_rst", OFS_DEBUG_PORT, DEBUG_PORT_RST);
    u_host.wr(OFS_BUF_SEL, 32'h0000_0005);
    rd_chk("buf_clear", OFS_BUF_CFG, 32'h0000_0000);
    u_host.wr(OFS_BUF_CFG, 32'h1234_5678);
    rd_chk("buf_wr", OFS_BUF_CFG, 32'h1234_5678);
    rd_chk("unmapped", 8'h3c, UNMAPPED_DATA);
    $display("Test reset done");
  endtask

  task automatic t_states();
    logic [31:0] mode [3];
    ccs_state_type dest [3];
    mode = '{32'h0000_0004, 32'h0000_0008, 32'h0000_0030};
    dest = '{ST_DEBUG, ST_LISTEN_ONLY, ST_SLEEP};
    st_go(32'h0, ST_NORMAL_ACTIVE);
    chk_val("act_flags", 32'h1f, 32'(flags));
    st_go(32'h2, ST_DIAG_STOP);
    chk_val("diag_flags", 32'h1, 32'(flags));
    st_go(32'h0, ST_DIAG_STOP);
    st_go(32'h1, ST_CONFIG);
    st_go(32'h0, ST_NORMAL_ACTIVE);
    sync_failed <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_val("sync_wait", 32'(ST_NORMAL_ACTIVE), 32'(state_code));
    cycle_end <= 1'b1;
    @(posedge ref_clk);
    cycle_end <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_val("passive", 32'(ST_NORMAL_PASSIVE), 32'(state_code));
    chk_val("pas_flags", 32'h17, 32'(flags));
    st_go(32'h1, ST_CONFIG);
    sync_failed <= 1'b0;
    rd_chk("buf_kept", OFS_BUF_CFG, 32'h1234_5678);
    for (int i = 0; i < 3; i++) begin
      st_go(32'h0, ST_NORMAL_ACTIVE);
      st_go(mode[i], dest[i]);
      st_go(32'h1, ST_CONFIG);
    end
    $display("Test states done");
  endtask

  task automatic t_debug();
    u_host.wr(OFS_DEBUG_PORT, 32'h0000_0053);
    debug_func_in <= 16'h0008;
    repeat (6) @(posedge ref_clk);
    chk_val("dbg_a", 32'h1, 32'({debug_out2, debug_out1}));
    debug_func_in <= 16'h0020;
    repeat (6) @(posedge ref_clk);
    chk_val("dbg_b", 32'h2, 32'({debug_out2, debug_out1}));
    u_host.wr(OFS_DEBUG_PORT, 32'h0000_0055);
    repeat (6) @(posedge ref_clk);
    chk_val("dbg_same", 32'h3, 32'({debug_out2, debug_out1}));
    guardian_attached <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_val("dbg_guard", 32'h0, 32'({debug_out2, debug_out1}));
    guardian_attached <= 1'b0;
    $display("Test debug done");
  endtask

  task automatic meas(output int n);
    n = 0;
    while (ext_ref_clock_out !== 1'b0) @(posedge ref_clk);
    while (ext_ref_clock_out !== 1'b1) @(posedge ref_clk);
    while (ext_ref_clock_out === 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
  endtask

  task automatic t_clock();
    logic [1:0] sel [4];
    logic [31:0] half [4];
    int n;
    int hi;
    sel = '{2'b00, 2'b01, 2'b10, 2'b00};
    half = '{HALF_4, HALF_10, HALF_40, HALF_4};
    hi = 0;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (POR_T - 2) begin
      @(posedge ref_clk);
      if (ext_ref_clock_out !== 1'b0) hi++;
    end
    chk_val("por_quiet", 32'h0, 32'(hi));
    for (int i = 0; i < 4; i++) begin
      {freq_sel1, freq_sel0} <= sel[i];
      repeat (100) @(posedge ref_clk);
      meas(n);
      chk_val("half_period", half[i], 32'(n));
      if (i == 2) begin
        {freq_sel1, freq_sel0} <= 2'b11;
        repeat (20) @(posedge ref_clk);
        repeat (60) begin
          @(posedge ref_clk);
          if (ext_ref_clock_out !== 1'b0) hi++;
        end
        chk_val("clk_off", 32'h0, 32'(hi));
      end
    end
    $display("Test clock done");
  endtask

  initial begin
    t_reset();
    t_states();
    t_debug();
    t_clock();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule
